/* File: hdl/dit_consts.vh */
`ifndef DIT_CONSTS_VH
`define DIT_CONSTS_VH
// Register addresses (16-bit special function register space)
`define DIT_ADDR_CNT_A 16'hff60
`define DIT_ADDR_CNT_B 16'hff61
`define DIT_ADDR_CMP_A 16'hff62
`define DIT_ADDR_CMP_B 16'hff63
`define DIT_ADDR_MODE_A 16'hff68
`define DIT_ADDR_MODE_B 16'hff69
`define DIT_ADDR_CSEL_A 16'hff6c
`define DIT_ADDR_CSEL_B 16'hff6d
// Field positions
`define DIT_MODE_EN_BIT 7
`define DIT_MODE_PWM_BIT 6
`define DIT_MODE_CASC_BIT 4
// Reset values
`define DIT_RST_BYTE 8'h00
// Clock select codes
`define DIT_CSEL_DIV4 3'h2
`define DIT_CSEL_DIV8 3'h3
`define DIT_CSEL_DIV16 3'h4
`define DIT_CSEL_DIV32 3'h5
`define DIT_CSEL_DIV128 3'h6
`define DIT_CSEL_DIV512 3'h7
`endif

/* File: hdl/dit_timer.v */
`timescale 1ns/1ns
`include "dit_consts.vh"
module dit_timer
(
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Processor register port
    input wire [15:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    // Read data and interrupts
    output reg [7:0] o_rdata,
    output reg o_match_irq_a,
    output reg o_match_irq_b
);

    // ************************************************************
    // Divider tap selection
    // ************************************************************
    // One-cycle tick when the free prescaler reaches the chosen tap
    function tick_sel;
        input [2:0] sel;
        input [8:0] pre;
        begin
            case (sel)
                `DIT_CSEL_DIV4: tick_sel = (pre[1:0] == 2'h3);
                `DIT_CSEL_DIV8: tick_sel = (pre[2:0] == 3'h7);
                `DIT_CSEL_DIV16: tick_sel = (pre[3:0] == 4'hf);
                `DIT_CSEL_DIV32: tick_sel = (pre[4:0] == 5'h1f);
                `DIT_CSEL_DIV128: tick_sel = (pre[6:0] == 7'h7f);
                `DIT_CSEL_DIV512: tick_sel = (pre[8:0] == 9'h1ff);
                default: tick_sel = 1'b0;
            endcase
        end
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    reg [7:0] cnt_a_q; // Counter a
    reg [7:0] cnt_b_q; // Counter b
    reg [7:0] cmp_a_q; // Compare value a
    reg [7:0] cmp_b_q; // Compare value b
    reg en_a_q; // Count enable a
    reg en_b_q; // Count enable b
    reg pwm_a_q; // Mode bit a, stored only
    reg pwm_b_q; // Mode bit b, stored only
    reg casc_q; // Cascade select
    reg [2:0] csel_a_q; // Clock select a
    reg [2:0] csel_b_q; // Clock select b
    reg [8:0] pre_a_q; // Prescaler a
    reg [8:0] pre_b_q; // Prescaler b

    // Read of a counter holds off its count clock this cycle
    wire rd_hold_a = i_rd && (i_addr == `DIT_ADDR_CNT_A || (casc_q && i_addr == `DIT_ADDR_CNT_B));
    wire rd_hold_b = i_rd && (i_addr == `DIT_ADDR_CNT_B);
    // Count ticks; in cascade the b counter uses a's clock
    wire tick_a = en_a_q && !rd_hold_a && tick_sel(csel_a_q, pre_a_q);
    wire tick_b_dis = en_b_q && !rd_hold_b && tick_sel(csel_b_q, pre_b_q);
    wire match_a = (cnt_a_q == cmp_a_q);
    wire match_b = (cnt_b_q == cmp_b_q);
    // Cascade: full match needs a and b both at compare; a matching alone only steps b and keeps counting
    wire casc_full = match_a && match_b;

    // ************************************************************
    // Prescalers: run only while enabled (b only outside cascade), cleared otherwise
    // ************************************************************
    // Starting from zero is why first match comes after a full period, with no slip
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pre_a_q <= 9'h000;
            pre_b_q <= 9'h000;
        end
        else
        begin
            if (en_a_q)
                pre_a_q <= pre_a_q + 9'h001;
            else
                pre_a_q <= 9'h000;
            if (en_b_q && !casc_q)
                pre_b_q <= pre_b_q + 9'h001;
            else
                pre_b_q <= 9'h000;
        end
    end

    // ************************************************************
    // Control register writes
    // ************************************************************
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cmp_a_q <= `DIT_RST_BYTE;
            cmp_b_q <= `DIT_RST_BYTE;
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
            casc_q <= 1'b0;
            csel_a_q <= 3'h0;
            csel_b_q <= 3'h0;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `DIT_ADDR_CMP_A: cmp_a_q <= i_wdata;
                `DIT_ADDR_CMP_B: cmp_b_q <= i_wdata;
                `DIT_ADDR_MODE_A:
                begin
                    en_a_q <= i_wdata[`DIT_MODE_EN_BIT];
                    pwm_a_q <= i_wdata[`DIT_MODE_PWM_BIT];
                end
                `DIT_ADDR_MODE_B:
                begin
                    en_b_q <= i_wdata[`DIT_MODE_EN_BIT];
                    pwm_b_q <= i_wdata[`DIT_MODE_PWM_BIT];
                    casc_q <= i_wdata[`DIT_MODE_CASC_BIT];
                end
                // Upper bits are dropped; software keeps them zero
                `DIT_ADDR_CSEL_A: csel_a_q <= i_wdata[2:0];
                `DIT_ADDR_CSEL_B: csel_b_q <= i_wdata[2:0];
                default:
                begin
                    en_a_q <= en_a_q;
                end
            endcase
        end
    end

    // ************************************************************
    // Counters and match interrupts
    // ************************************************************
    // Equality only: a compare set below the count wraps past ff first
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_a_q <= 8'h00;
            cnt_b_q <= 8'h00;
            o_match_irq_a <= 1'b0;
            o_match_irq_b <= 1'b0;
        end
        else
        begin
            o_match_irq_a <= 1'b0;
            o_match_irq_b <= 1'b0;
            // Counter a
            if (!en_a_q)
                cnt_a_q <= 8'h00;
            else if (tick_a)
            begin
                if (match_a && (!casc_q || casc_full))
                begin
                    cnt_a_q <= 8'h00;
                    o_match_irq_a <= 1'b1;
                end
                else
                    cnt_a_q <= cnt_a_q + 8'h01;
            end
            // Counter b
            if (!en_b_q)
                cnt_b_q <= 8'h00;
            else if (casc_q)
            begin
                if (tick_a && match_a)
                begin
                    if (casc_full)
                        cnt_b_q <= 8'h00;
                    else
                        cnt_b_q <= cnt_b_q + 8'h01;
                end
                if (tick_a && match_b)
                    o_match_irq_b <= 1'b1;
            end
            else if (tick_b_dis)
            begin
                if (match_b)
                begin
                    cnt_b_q <= 8'h00;
                    o_match_irq_b <= 1'b1;
                end
                else
                    cnt_b_q <= cnt_b_q + 8'h01;
            end
        end
    end

    // ************************************************************
    // Read data, registered one cycle after the strobe
    // ************************************************************
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `DIT_ADDR_CNT_A: o_rdata <= cnt_a_q;
                `DIT_ADDR_CNT_B: o_rdata <= cnt_b_q;
                `DIT_ADDR_CMP_A: o_rdata <= cmp_a_q;
                `DIT_ADDR_CMP_B: o_rdata <= cmp_b_q;
                `DIT_ADDR_MODE_A: o_rdata <= {en_a_q, pwm_a_q, 6'h00};
                `DIT_ADDR_MODE_B: o_rdata <= {en_b_q, pwm_b_q, 1'b0, casc_q, 4'h0};
                `DIT_ADDR_CSEL_A: o_rdata <= {5'h00, csel_a_q};
                `DIT_ADDR_CSEL_B: o_rdata <= {5'h00, csel_b_q};
                default: o_rdata <= 8'h00;
            endcase
        end
    end

endmodule // dit_timer

/* File: bench/dit_timer_asserts.sv */
`timescale 1ns/1ns
// ****
// Port checker
// ****
module dit_timer_asserts
(
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Register port
    input wire [15:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    // Results
    input wire [7:0] o_rdata,
    input wire o_match_irq_a,
    input wire o_match_irq_b
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (!i_rst_n);
// Fastest count clock is divide by 4
AST_GAP_A: assert property
    (o_match_irq_a |=> !o_match_irq_a [*3]) else $error("irq a too close");
AST_GAP_B: assert property
    (o_match_irq_b |=> !o_match_irq_b [*3]) else $error("irq b too close");
AST_CSEL_HI: assert property
    (i_rd && i_addr == 16'hff6c |=> o_rdata[7:3] == 5'h00) else $error("select high bits");
AST_CSEL_RB: assert property
    (i_wr && i_addr == 16'hff6d ##1 i_rd && i_addr == 16'hff6d |=> o_rdata == {5'h00, $past(i_wdata[2:0], 2)})
    else $error("select readback");
AST_UNMAP: assert property
    (i_rd && i_addr == 16'h0000 |=> o_rdata == 8'h00) else $error("unmapped read");
// Read data only moves on a read
AST_HOLD: assert property
    (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
// Counter clears on the edge after the enable drops, so the read comes two cycles on
AST_STOP_CLR: assert property
    (i_wr && i_addr == 16'hff68 && !i_wdata[7] ##2 i_rd && i_addr == 16'hff60 |=> o_rdata == 8'h00)
    else $error("stopped counter not zero");
AST_RST_IDLE: assert property
    ($rose(i_rst_n) |-> !o_match_irq_a && !o_match_irq_b) else $error("irq after reset");
endmodule // dit_timer_asserts
bind dit_timer dit_timer_asserts dit_timer_asserts_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_match_irq_a(o_match_irq_a), .o_match_irq_b(o_match_irq_b));

/* File: bench/tb.sv */
`timescale 1ns/1ns
// ****
// Testbench
// ****
module tb;
reg clk = 0, rst_n = 0, wr = 0, rd = 0;
reg [15:0] addr = 16'h0000;
reg [7:0] wdata = 8'h00, v;
wire [7:0] rdata;
wire irq_a, irq_b;
integer fails = 0, num_checks = 0, n, k, j;
initial forever #20 clk = ~clk;
dit_timer dit_timer_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .o_match_irq_a(irq_a), .o_match_irq_b(irq_b));
task conclude;
begin
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
task chkn(input integer got, input integer exp);
begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
        fails = fails + 1;
        $display("mismatch at %0t: got %0d exp %0d", $time, got, exp);
    end
end
endtask
// One bus cycle; strobe stays up so back to back calls never retoggle it
task acc(input w, input [15:0] a, input [7:0] d);
begin
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    v = rdata;
end
endtask
task idle;
begin
    wr = 0;
    rd = 0;
    @(negedge clk);
end
endtask
task rc(input [15:0] a, input [7:0] e);
begin
    acc(0, a, 8'h00);
    chkn({24'h0, v} === {24'h0, e}, 1);
end
endtask
// Bounded wait for a pulse; n ends as cycles waited
task wirq(input s, input integer lim);
begin
    n = 0;
    while ((s ? irq_b : irq_a) !== 1'b1 && n < lim)
    begin
        @(negedge clk);
        n = n + 1;
    end
    if (n >= lim)
    begin
        fails = fails + 1;
        $display("mismatch at %0t: no irq", $time);
        conclude;
    end
    @(negedge clk);
end
endtask
task quiet(input s, input integer c);
begin
    k = 0;
    repeat (c)
    begin
        @(negedge clk);
        if ((s ? irq_b : irq_a) !== 1'b0)
            k = k + 1;
    end
    chkn(k, 0);
end
endtask
initial
begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    rc(16'hff6c, 8'h00);
    rc(16'hff6d, 8'h00);
    acc(1, 16'hff6d, 8'h07);
    rc(16'hff6d, 8'h07);
    acc(1, 16'h0000, 8'h5a);
    rc(16'h0000, 8'h00);
    idle;
    $display("regs done");
    // Every legal code, compare of 1 gives two count clocks
    acc(1, 16'hff62, 8'h01);
    for (j = 2; j < 8; j = j + 1)
    begin
        acc(1, 16'hff68, 8'h00);
        acc(1, 16'hff6c, j[7:0]);
        acc(1, 16'hff68, 8'h80);
        idle;
        wirq(0, 3000);
        wirq(0, 3000);
        chkn(n + 1, 2 * ((j < 6) ? (1 << j) : (1 << (2 * j - 5))));
    end
    acc(1, 16'hff62, 8'h03);
    acc(1, 16'hff68, 8'h00);
    acc(1, 16'hff6c, 8'h02);
    acc(1, 16'hff68, 8'h80);
    idle;
    wirq(0, 200);
    wirq(0, 200);
    chkn(n + 1, 16);
    wirq(0, 200);
    chkn(n + 1, 16);
    // Stop mid-count so a missing clear would show a nonzero count
    repeat (9) @(negedge clk);
    acc(1, 16'hff68, 8'h00);
    idle;
    rc(16'hff60, 8'h00);
    acc(1, 16'hff6c, 8'h01);
    acc(1, 16'hff68, 8'h80);
    idle;
    quiet(0, 600);
    acc(1, 16'hff68, 8'h00);
    acc(1, 16'hff63, 8'h02);
    acc(1, 16'hff6d, 8'h03);
    acc(1, 16'hff69, 8'h80);
    idle;
    wirq(1, 200);
    wirq(1, 200);
    chkn(n + 1, 24);
    acc(1, 16'hff69, 8'h00);
    $display("discrete done");
    // Compare lowered below a running count must wrap first
    acc(1, 16'hff62, 8'hc8);
    acc(1, 16'hff6c, 8'h02);
    acc(1, 16'hff68, 8'h80);
    idle;
    repeat (60) @(negedge clk);
    acc(1, 16'hff62, 8'h03);
    idle;
    quiet(0, 800);
    wirq(0, 400);
    // Lowered compare followed by a restart gives the new period at once
    acc(1, 16'hff62, 8'h01);
    acc(1, 16'hff68, 8'h00);
    acc(1, 16'hff68, 8'h80);
    idle;
    wirq(0, 200);
    wirq(0, 200);
    chkn(n + 1, 8);
    acc(1, 16'hff68, 8'h00);
    $display("wrap done");
    // Cascade: second select left at zero must not matter
    acc(1, 16'hff62, 8'h01);
    acc(1, 16'hff63, 8'h01);
    acc(1, 16'hff6d, 8'h00);
    acc(1, 16'hff6c, 8'h02);
    acc(1, 16'hff69, 8'h90);
    acc(1, 16'hff68, 8'h80);
    idle;
    wirq(0, 1200);
    wirq(0, 1200);
    chkn(n + 1, 1032);
    wirq(1, 1200);
    acc(1, 16'hff68, 8'h00);
    idle;
    quiet(0, 1100);
    rc(16'hff61, 8'h01);
    j = v;
    acc(0, 16'hff61, 8'h00);
    chkn(v === j[7:0], 1);
    acc(1, 16'hff68, 8'h80);
    idle;
    wirq(0, 1200);
    acc(1, 16'hff68, 8'h00);
    acc(1, 16'hff69, 8'h00);
    idle;
    $display("cascade done");
    conclude;
end
endmodule // tb
